// >>> fws_host.sv
// Host sequencer that polls write-operation status of a parallel NOR flash
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_host
  import fws_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = `GAP_CYC  // 50 us spacing window in cycles
) (
  input  logic        i_clk_sys,
  input  logic        i_rst_n,
  input  reg_req_t    i_req,
  output logic [31:0] o_rdata,
  input  logic [7:0]  i_dq,
  input  logic        i_ready_busy,
  output flash_out_t  o_flash,
  output logic        o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  state_t      state;        // Sequencer state
  logic [19:0] addr;         // Target or status address
  logic [7:0]  wdata;        // Data for a raw write
  logic        skip_cfg;     // Allow skipping window checks
  logic [7:0]  dq_s1;        // Data bus first sync stage
  logic [7:0]  dq_s2;        // Data bus second sync stage
  logic        rb_s1;        // Ready/busy first sync stage
  logic        rb_s2;        // Ready/busy second sync stage
  logic        bus_act;      // Bus cycle in progress
  logic        bus_done;     // Bus cycle finished, one cycle
  logic [3:0]  bus_cnt;      // Cycle count within a bus cycle
  logic [7:0]  rd_data;      // Last byte read from the flash
  logic [7:0]  prev_data;    // Byte of the previous status read
  logic        done;         // Command finished
  logic        fail;         // Operation failed, reset written
  logic        rejected;     // Add refused, window already closed
  logic        maybe_rej;    // Window closed after the add
  logic        no_accept;    // Erase sequence not seen running
  logic        abort_req;    // Stop polling at next decision
  logic        check_post;   // Read window flag after the add
  logic [12:0] gap_cnt;      // Cycles since last sector add
  logic        cmd_wr;       // Command register written
  logic [2:0]  cmd;          // Command code on the write
  logic        toggled;      // First toggle bit changed
  logic        skip_ok;      // Window check may be skipped
  logic        go;           // Start a bus cycle
  logic        wr_op;        // Current state performs a write

  assign cmd_wr  = i_req.wr && (i_req.addr == `OFS_CMD);
  assign cmd     = i_req.wdata[2:0];
  assign toggled = rd_data[`BIT_TB1] != prev_data[`BIT_TB1];
  assign skip_ok = skip_cfg && (gap_cnt < 13'(GAP_CYCLES));
  assign go      = (state != ST_IDLE) && !bus_act && !bus_done;
  assign wr_op   = state inside {ST_WR, ST_RST, ST_ADD};
  assign o_busy  = state != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
      rb_s1 <= i_ready_busy;
      rb_s2 <= rb_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software register writes, held while a command runs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      addr     <= 20'h00000;
      wdata    <= 8'h00;
      skip_cfg <= 1'b0;
    end else if (i_req.wr && state == ST_IDLE) begin
      // Decode the written register
      case (i_req.addr)
        `OFS_ADDR: addr <= i_req.wdata[19:0];
        `OFS_DATA: wdata <= i_req.wdata[7:0];
        `OFS_CFG:  skip_cfg <= i_req.wdata[0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software register reads, data in the following cycle only
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `OFS_ADDR: o_rdata <= {12'h000, addr};
        `OFS_DATA: o_rdata <= {24'h000000, wdata};
        `OFS_STAT: o_rdata <= {16'h0000, rd_data, 1'b0, rb_s2, no_accept, maybe_rej, rejected, fail, done, o_busy};
        `OFS_CFG:  o_rdata <= {31'h00000000, skip_cfg};
        default:   o_rdata <= 32'h00000000;  // Unmapped reads give zero
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash bus cycle engine; chip enable rises between cycles so each read toggles
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bus_act       <= 1'b0;
      bus_done      <= 1'b0;
      bus_cnt       <= 4'h0;
      rd_data       <= 8'h00;
      o_flash.addr  <= 20'h00000;
      o_flash.dq_o  <= 8'h00;
      o_flash.dq_oe <= 1'b0;
      o_flash.ce_n  <= 1'b1;
      o_flash.oe_n  <= 1'b1;
      o_flash.we_n  <= 1'b1;
    end else begin
      bus_done <= 1'b0;
      if (go) begin
        // Open a cycle at the held address
        bus_act       <= 1'b1;
        bus_cnt       <= 4'h0;
        o_flash.addr  <= addr;
        o_flash.dq_o  <= (state == ST_WR) ? wdata : (state == ST_RST) ? `FL_RESET : `FL_SECTOR;
        o_flash.dq_oe <= wr_op;
        o_flash.ce_n  <= 1'b0;
        o_flash.oe_n  <= wr_op;
        o_flash.we_n  <= !wr_op;
      end else if (bus_act) begin
        bus_cnt <= bus_cnt + 4'h1;
        // End the write pulse, data held until the cycle closes
        if (bus_cnt == 4'(`WE_CYC)) begin
          o_flash.we_n <= 1'b1;
        end
        // Close the cycle, sample read data past the synchroniser
        if (bus_cnt == 4'(`END_CYC)) begin
          bus_act       <= 1'b0;
          bus_done      <= 1'b1;
          o_flash.ce_n  <= 1'b1;
          o_flash.oe_n  <= 1'b1;
          o_flash.we_n  <= 1'b1;
          o_flash.dq_oe <= 1'b0;
          if (!o_flash.oe_n) begin
            rd_data <= dq_s2;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time since the last sector add, saturating
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      gap_cnt <= 13'h1fff;
    end else if (state == ST_ADD && bus_done) begin
      gap_cnt <= 13'h0000;
    end else if (gap_cnt != 13'h1fff) begin
      gap_cnt <= gap_cnt + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state      <= ST_IDLE;
      prev_data  <= 8'h00;
      done       <= 1'b0;
      fail       <= 1'b0;
      rejected   <= 1'b0;
      maybe_rej  <= 1'b0;
      no_accept  <= 1'b0;
      abort_req  <= 1'b0;
      check_post <= 1'b0;
    end else begin
      // Abort only matters while polling
      if (cmd_wr && cmd == `CMD_ABORT && state != ST_IDLE) begin
        abort_req <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_wr) begin
            // Flags clear only here, so a set never meets a clear
            done      <= 1'b0;
            fail      <= 1'b0;
            rejected  <= 1'b0;
            maybe_rej <= 1'b0;
            no_accept <= 1'b0;
            abort_req <= 1'b0;
            case (cmd)
              `CMD_READ:    state <= ST_RD;
              `CMD_WRITE:   state <= ST_WR;
              `CMD_POLL:    state <= ST_P_A;
              `CMD_ADD: begin
                check_post <= !skip_ok;
                state      <= skip_ok ? ST_ADD : ST_PRE;
              end
              `CMD_CONFIRM: state <= ST_CF_A;
              default: ;
            endcase
          end
        end
        default: begin
          if (bus_done) begin
            prev_data <= rd_data;
            case (state)
              // First read only notes the toggle bit
              ST_P_A: state <= ST_P_B;
              ST_P_B: begin
                if (!toggled) begin
                  state <= ST_IDLE;
                  done  <= 1'b1;
                end else if (rd_data[`BIT_TLIM]) begin
                  state <= ST_P_C;
                end else if (abort_req) begin
                  state <= ST_IDLE;
                end
              end
              // Recheck after the limit flag rose
              ST_P_C: begin
                if (toggled) begin
                  fail  <= 1'b1;
                  state <= ST_RST;
                end else begin
                  state <= ST_IDLE;
                  done  <= 1'b1;
                end
              end
              // Window check before the add
              ST_PRE: begin
                if (rd_data[`BIT_WIN]) begin
                  rejected <= 1'b1;
                  done     <= 1'b1;
                  state    <= ST_IDLE;
                end else begin
                  state <= ST_ADD;
                end
              end
              ST_ADD: begin
                if (check_post) begin
                  state <= ST_POST;
                end else begin
                  done  <= 1'b1;
                  state <= ST_IDLE;
                end
              end
              // Window check after the add
              ST_POST: begin
                maybe_rej <= rd_data[`BIT_WIN];
                done      <= 1'b1;
                state     <= ST_IDLE;
              end
              ST_CF_A: state <= ST_CF_B;
              ST_CF_B: begin
                if (toggled) begin
                  state <= ST_CF_W;
                end else begin
                  no_accept <= 1'b1;
                  done      <= 1'b1;
                  state     <= ST_IDLE;
                end
              end
              // Single read, single write, reset write, window read
              default: begin
                done  <= 1'b1;
                state <= ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  chk_poll_two_reads: assert property (state == ST_P_A && bus_done |=> state == ST_P_B)
    else $error("first status read not followed by second");
  chk_fail_recheck: assert property (state == ST_P_B && bus_done && toggled && rd_data[`BIT_TLIM]
    |=> state == ST_P_C)
    else $error("no recheck after limit flag");
  chk_fail_source: assert property ($rose(fail) |-> $past(state) == ST_P_C)
    else $error("failure flagged without recheck");
  chk_poll_restart: assert property (state == ST_IDLE && cmd_wr && cmd == `CMD_POLL
    |=> state == ST_P_A ##1 !o_flash.ce_n)
    else $error("poll did not restart at first read");
  chk_reset_write: assert property (state == ST_P_C && bus_done && toggled
    |=> state == ST_RST ##1 (o_flash.dq_oe && o_flash.dq_o == `FL_RESET && !o_flash.we_n))
    else $error("reset command not written after failure");
  chk_gap_check: assert property (state == ST_IDLE && cmd_wr && cmd == `CMD_ADD && !skip_ok
    |=> state == ST_PRE)
    else $error("window check skipped outside spacing");
  chk_window_post: assert property (state == ST_ADD && bus_done && check_post |=> state == ST_POST)
    else $error("window flag not read after add");
  chk_confirm_order: assert property (state == ST_CF_W && $past(state) != ST_CF_W
    |-> $past(state) == ST_CF_B && $past(toggled))
    else $error("window read before acceptance seen");
  chk_status_addr: assert property (state inside {ST_P_A, ST_P_B, ST_P_C, ST_PRE, ST_POST} && !o_flash.ce_n
    |-> o_flash.addr == addr)
    else $error("status read at wrong address");

endmodule

// >>> fws_regs.svh
// Register offsets, status bit positions, flash command bytes and timing counts
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH
// Register offsets (byte addresses on the software port)
`define OFS_CMD    8'h00
`define OFS_ADDR   8'h04
`define OFS_DATA   8'h08
`define OFS_STAT   8'h0c
`define OFS_CFG    8'h10
// Command codes written to the command register
`define CMD_READ    3'h1
`define CMD_WRITE   3'h2
`define CMD_POLL    3'h3
`define CMD_ADD     3'h4
`define CMD_CONFIRM 3'h5
`define CMD_ABORT   3'h6
// Status bit positions on the flash data bus
`define BIT_POLL   7
`define BIT_TB1    6
`define BIT_TLIM   5
`define BIT_WIN    3
`define BIT_TB2    2
// Flash command bytes
`define FL_RESET   8'hf0
`define FL_SECTOR  8'h30
// Timing: figures in ns or us, cycle counts derived from the clock period
`define CLK_NS     10
`define ACC_NS     70
`define ACC_CYC    ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC   2
`define END_CYC    (`ACC_CYC + `SYNC_CYC)
`define WE_NS      35
`define WE_CYC     ((`WE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_US     50
`define GAP_CYC    (`GAP_US * 1000 / `CLK_NS)
`endif

// >>> fws_pkg.sv
// Types shared by the flash status polling host
package fws_pkg;
  // Pins driven toward the flash
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } flash_out_t;
  // One software register request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD, ST_WR, ST_P_A, ST_P_B, ST_P_C, ST_RST,
    ST_PRE, ST_ADD, ST_POST, ST_CF_A, ST_CF_B, ST_CF_W
  } state_t;
endpackage

// >>> flash_model.sv
// Behavioural parallel flash that reports write-operation status on its data bus
`timescale 1ns/1ps
module flash_model #(
  parameter real WIN_NS = 1000.0  // Shortened sector erase acceptance time-out
) (
  input  wire logic [19:0] i_addr,
  input  wire logic [7:0]  i_dq_o,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic      [7:0]  o_dq,
  output logic             o_ready_busy
);
  int          busy_left = 0;     // Reads left before the embedded run ends
  logic        limit     = 1'b0;  // Pulse count overrun, set by the bench
  logic        erasing   = 1'b0;  // Sector erase pending or running
  logic        window    = 1'b0;  // Acceptance time-out has expired
  logic        tog_one   = 1'b0;  // First toggle bit state
  logic        tog_two   = 1'b0;  // Second toggle bit state
  logic [7:0]  prog      = 8'h00; // Last programmed byte
  logic [7:0]  prev_byte = 8'h00; // Last byte put on the bus
  logic [19:0] sec       = 20'h0; // Selected sector address
  logic [19:0] last_addr = 20'h0; // Address of the last read
  int          reads     = 0;     // Completed read cycles
  int          resets    = 0;     // Reset commands seen
  int          sectors   = 0;     // Sector erase commands accepted
  realtime     t_add     = 0;     // Time of the last accepted sector command
  logic        sel;               // Read cycle in progress
  logic        wsel;              // Write cycle in progress
  logic        stat_mode;         // Status output instead of array data
  logic        run;               // Embedded run in progress
  logic        susp      = 1'b0;  // Sector erase suspended
  logic        in_sec;            // Read address lies in the erase sector
  logic [7:0]  rd_val;            // Byte returned by the current read

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and status byte
  always @* begin
    sel       = !i_ce_n && !i_oe_n;
    wsel      = !i_ce_n && !i_we_n;
    in_sec    = erasing && (i_addr[19:12] == sec[19:12]);
    // A suspended erase keeps only its last selected sector in status mode
    run       = (busy_left > 0) || limit || (erasing && !susp);
    stat_mode = run || (susp && in_sec);
    // Polling bit, toggles, limit flag, window flag
    rd_val    = stat_mode ? {erasing ? susp : ~prog[7], tog_one, limit, 1'b0, window, tog_two, 2'b00}
                          : (i_addr[7:0] ^ 8'h5a);
    // Released bus shows the inverse of the last byte, never a stale copy
    o_dq      = sel ? rd_val : ~prev_byte;
  end
  // Busy while a run is in progress
  assign o_ready_busy = !run;

  ////////////////////////////////////////////////////////////////////////////
  // Window flag latches once the time-out has run out
  always @(posedge sel) begin
    window = window || (erasing && ($realtime - t_add > WIN_NS));
  end
  // End of a read cycle advances the toggle bits
  always @(negedge sel) begin
    prev_byte = rd_val;
    last_addr = i_addr;
    reads++;
    if (stat_mode) begin
      // First toggle bit holds still while the erase is suspended
      if (!susp) begin
        tog_one = ~tog_one;
      end
      if (in_sec) begin
        tog_two = ~tog_two;
      end
    end
    // Run ends on its own unless the limit was exceeded
    if (busy_left > 0 && !limit) begin
      busy_left--;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at the end of a write cycle
  always @(negedge wsel) begin
    if (i_dq_o == 8'hf0) begin
      // Reset returns to array read and clears the failure
      busy_left = 0;
      limit     = 1'b0;
      erasing   = 1'b0;
      window    = 1'b0;
      susp      = 1'b0;
      resets++;
    end else if (i_dq_o == 8'h30) begin
      // Extra sectors only while the window is open; time-out restarts
      // Only this sector command arms the window
      if (!window) begin
        erasing = 1'b1;
        sec     = i_addr;
        t_add   = $realtime;
        sectors++;
      end
    end else if (i_dq_o == 8'hb0 && erasing) begin
      // Suspend releases ready/busy and freezes the first toggle bit
      susp = 1'b1;
    end else if (!stat_mode) begin
      prog = i_dq_o;
    end
  end
endmodule

// >>> tb.sv
// Self-checking testbench for the flash status polling host
`timescale 1ns/1ps
`include "fws_regs.svh"
module tb;
  import fws_pkg::*;
  logic        i_clk_sys;  // System clock
  logic        i_rst_n;    // Synchronous reset, active low
  reg_req_t    req;        // Register port request
  logic [31:0] rdata;      // Register read data
  logic [7:0]  dq;         // Flash data bus toward the host
  logic        rb;         // Flash ready/busy
  flash_out_t  fl;         // Flash pins from the host
  logic        busy;       // Host command in progress
  logic [31:0] d;          // Last register value read
  int          err_count;  // Mismatches
  int          num_checks; // Comparisons
  int          n;          // Read count snapshot
  int          s;          // Sector count snapshot

  fws_host #(.GAP_CYCLES(20)) fws_host_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata),
    .i_dq(dq), .i_ready_busy(rb), .o_flash(fl), .o_busy(busy));
  flash_model flash_model_inst (
    .i_addr(fl.addr), .i_dq_o(fl.dq_o), .i_ce_n(fl.ce_n), .i_oe_n(fl.oe_n),
    .i_we_n(fl.we_n), .o_dq(dq), .o_ready_busy(rb));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port tasks and comparison
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    req <= '0;
    #1 v = rdata;
  endtask
  task automatic wait_idle();
    int i;
    repeat (2) @(posedge i_clk_sys);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge i_clk_sys);
    if (busy !== 1'b0) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(`OFS_CMD, {29'h0, c});
    wait_idle();
    rd(`OFS_STAT, d);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    err_count  = 0;
    num_checks = 0;
    i_rst_n    = 1'b0;
    req        = '0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Ready/busy needs two synchroniser edges before status shows it
    repeat (2) @(posedge i_clk_sys);
    // Idle values, command register and unmapped read
    rd(`OFS_STAT, d);
    check(d, 32'h40);
    check({fl.ce_n, fl.oe_n, fl.we_n, fl.dq_oe}, 4'he);
    rd(`OFS_CMD, d);
    check(d, 32'h0);
    rd(8'h14, d);
    check(d, 32'h0);
    // Array read and a poll of an idle device
    wr(`OFS_ADDR, 32'h03c21);
    cmd(`CMD_READ);
    check(d[15:8], 8'h7b);
    n = flash_model_inst.reads;
    cmd(`CMD_POLL);
    check(flash_model_inst.reads - n, 2);
    check(d[2:0], 3'b010);
    check(flash_model_inst.last_addr, 20'h03c21);
    // Run ends after three toggling reads
    flash_model_inst.busy_left = 3;
    cmd(`CMD_POLL);
    check(d[2:0], 3'b010);
    check(d[15:8], 8'h7b);
    // Limit exceeded: recheck, fail, reset command
    flash_model_inst.busy_left = 1;
    flash_model_inst.limit = 1'b1;
    n = flash_model_inst.reads;
    cmd(`CMD_POLL);
    check(d[2:0], 3'b110);
    check(flash_model_inst.reads - n, 3);
    check(flash_model_inst.resets, 1);
    check(flash_model_inst.limit, 1'b0);
    // Endless toggling, abort, then a fresh double read
    flash_model_inst.busy_left = 1000;
    wr(`OFS_CMD, {29'h0, `CMD_POLL});
    repeat (60) @(posedge i_clk_sys);
    rd(`OFS_STAT, d);
    check({d[6], d[0]}, 2'b01);
    wr(`OFS_CMD, {29'h0, `CMD_ABORT});
    wait_idle();
    rd(`OFS_STAT, d);
    check(d[1], 1'b0);
    flash_model_inst.busy_left = 0;
    n = flash_model_inst.reads;
    cmd(`CMD_POLL);
    check(flash_model_inst.reads - n, 2);
    // Raw byte write, then a status read while the program runs
    wr(`OFS_DATA, 32'h80);
    rd(`OFS_DATA, d);
    check(d, 32'h80);
    cmd(`CMD_WRITE);
    check(d[2:0], 3'b010);
    check(flash_model_inst.prog, 8'h80);
    flash_model_inst.busy_left = 1;
    cmd(`CMD_READ);
    check(d[15], 1'b0);
    // Sector add inside the window, then confirm
    wr(`OFS_ADDR, 32'h50008);
    wr(`OFS_CFG, 32'h0);
    rd(`OFS_ADDR, d);
    check(d, 32'h50008);
    n = flash_model_inst.reads;
    cmd(`CMD_ADD);
    check(d[4:3], 2'b00);
    check(flash_model_inst.sectors, 1);
    check(flash_model_inst.reads - n, 2);
    cmd(`CMD_CONFIRM);
    check({d[11], d[5]}, 2'b00);
    // Window expired: add is refused after the pre-read
    repeat (120) @(posedge i_clk_sys);
    n = flash_model_inst.reads;
    s = flash_model_inst.sectors;
    cmd(`CMD_ADD);
    check({d[11], d[4], d[3]}, 3'b101);
    check(flash_model_inst.sectors, s);
    check(flash_model_inst.reads - n, 1);
    cmd(`CMD_CONFIRM);
    check({d[11], d[5]}, 2'b10);
    // Closely spaced adds skip the window checks
    flash_model_inst.erasing = 1'b0;
    flash_model_inst.window = 1'b0;
    wr(`OFS_CFG, 32'h1);
    rd(`OFS_CFG, d);
    check(d, 32'h1);
    repeat (30) @(posedge i_clk_sys);
    s = flash_model_inst.sectors;
    n = flash_model_inst.reads;
    cmd(`CMD_ADD);
    check(flash_model_inst.reads - n, 2);
    n = flash_model_inst.reads;
    cmd(`CMD_ADD);
    check(flash_model_inst.reads - n, 0);
    check(flash_model_inst.sectors, s + 2);
    // Suspend the erase, then poll inside the suspended sector
    wr(`OFS_DATA, 32'hb0);
    cmd(`CMD_WRITE);
    n = flash_model_inst.reads;
    cmd(`CMD_POLL);
    check(flash_model_inst.reads - n, 2);
    check({d[15], d[13], d[6], d[2:0]}, 6'b101010);
    stop_test();
  end
endmodule
